//--- hw/banked_data_memory_decoder.sv
// banked data memory address decoder with general and common RAM
`timescale 1ns/1ps
// Summary of operation
// R01 - banks 0-59: 20-byte peripheral region after core
// R02 - banks 60-63: peripheral region is 100 bytes
// R03 - up to 80 general RAM bytes per bank
// R04 - linear unbanked view of general RAM
// R05 - offsets 70h-7Fh hit one shared common RAM
// R06 - unimplemented reads zero, writes ignored
// R07 - 13-bit address: 6 bank, 7 offset bits
// R08 - 64 banks of 128 bytes
// R09 - first 12 offsets are core registers everywhere
module banked_data_memory_decoder #(
	parameter int GRAM_BANKS = dmem_decode_pkg::GRAM_BANKS
) (
	input  wire logic        clk,          // system clock
	input  wire logic        rst,          // synchronous reset, high
	input  wire logic        reqValid,     // access request strobe
	input  wire logic        reqWrite,     // 1 write, 0 read
	input  wire logic        reqLinear,    // pointer-based linear access
	input  wire logic [12:0] reqAddr,      // banked or linear address
	input  wire logic [7:0]  reqWdata,     // write data
	input  wire logic [7:0]  coreRdata,    // read data from core regs
	input  wire logic [7:0]  periphRdata,  // read data from peripherals
	output logic             coreSel,      // core register access strobe
	output logic             periphSel,    // peripheral access strobe
	output logic [12:0]      regAddr,      // address to core/periph
	output logic [3:0]       coreIndex,    // core register index
	output logic [6:0]       periphIndex,  // index inside peripheral area
	output logic             rspValid,     // read data valid
	output logic [7:0]       rspData       // read data
);
	// sizes of the packed ram: general bytes of the first GRAM_BANKS banks, then common
	localparam int GRAM_DEPTH = GRAM_BANKS * dmem_decode_pkg::GRAM_MAX;
	localparam int RAM_DEPTH  = GRAM_DEPTH + dmem_decode_pkg::COMMON_BYTES;
	localparam int RAM_AW     = $clog2(RAM_DEPTH);
	// address field widths and table size
	localparam int AW         = dmem_decode_pkg::ADDR_W;
	localparam int BW         = dmem_decode_pkg::BANK_W;
	localparam int OW         = dmem_decode_pkg::OFS_W;
	localparam int NB         = dmem_decode_pkg::NUM_BANKS;
	localparam int CW         = $clog2(dmem_decode_pkg::COMMON_BYTES);

	// address fields of the request
	logic [BW-1:0]            bank;
	logic [OW-1:0]            ofs;

	// region limits of the selected bank
	logic                     longBank;
	logic [OW-1:0]            periphEnd;
	logic [OW-1:0]            gramStart;
	logic [OW-1:0]            gramOfs;

	// per-bank general ram table
	logic [AW-1:0]            bankBase [NB];
	logic [NB-1:0]            bankHasGram;

	// region hits and the winning region
	logic                     hitLinear;
	logic                     hitCore;
	logic                     hitCommon;
	logic                     hitPeriph;
	logic                     hitGram;
	logic [AW-1:0]            gramIdx;
	logic [AW-1:0]            linIdx;
	dmem_decode_pkg::region_t region;

	// memory port
	logic [RAM_AW-1:0]        ramAddr;
	logic                     ramWe;
	logic [7:0]               ramRdata;

	// response stage
	dmem_decode_pkg::region_t rspRegion_ff;
	dmem_decode_pkg::region_t nxt_rspRegion;
	logic                     rspValid_ff;
	logic                     nxt_rspValid;

	// bank in the upper bits, offset in the lower bits [R07] [R08]
	assign bank = reqAddr[AW-1:OW];
	assign ofs  = reqAddr[OW-1:0];

	// one entry per bank: where its slice of the packed general ram
	// starts, and whether it has one; a table keeps the multiplier off
	// the address path
	for (genvar gb = 0; gb < NB; gb++) begin : g_bank
		assign bankBase[gb]    = AW'(gb * dmem_decode_pkg::GRAM_MAX);
		assign bankHasGram[gb] = (gb < GRAM_BANKS);
	end

	// the top banks trade their general ram for a long peripheral region
	assign longBank = (bank >= BW'(dmem_decode_pkg::LONG_FIRST_BANK));

	always_comb begin
		if (longBank) begin
			periphEnd = OW'(dmem_decode_pkg::CORE_REGS
				+ dmem_decode_pkg::PERIPH_LONG); // [R02]
		end else begin
			periphEnd = OW'(dmem_decode_pkg::CORE_REGS
				+ dmem_decode_pkg::PERIPH_SHORT); // [R01]
		end
		gramStart = periphEnd;
		gramOfs   = ofs - gramStart;
	end

	// linear view packs every bank's general ram back to back [R04]
	assign linIdx  = reqAddr - dmem_decode_pkg::LIN_BASE_ADDR;
	assign gramIdx = bankBase[bank] + AW'(gramOfs);

	// hits can overlap (hitPeriph also covers the core offsets, hitGram also checks the bank); which one
	// wins is settled by the priority chain below
	always_comb begin
		hitLinear = 1'b0;
		hitCore   = 1'b0;
		hitCommon = 1'b0;
		hitPeriph = 1'b0;
		hitGram   = 1'b0;
		if (reqLinear) begin
			hitLinear = (linIdx < AW'(GRAM_DEPTH)); // [R04]
		end else begin
			hitCore   = (ofs < OW'(dmem_decode_pkg::CORE_REGS));
			hitCommon = (ofs >= OW'(dmem_decode_pkg::COMMON_BASE));
			hitPeriph = (ofs < periphEnd);
			hitGram   = bankHasGram[bank]
				&& (gramOfs < OW'(dmem_decode_pkg::GRAM_MAX)); // [R03]
		end
	end

	// core registers beat everything, common ram beats the bank's own
	// regions; an offset claimed by no region is a hole [R06]
	always_comb begin
		region  = dmem_decode_pkg::REG_NONE;
		ramAddr = '0;
		if (hitLinear) begin
			region  = dmem_decode_pkg::REG_GRAM; // [R04]
			ramAddr = RAM_AW'(linIdx);
		end else if (hitCore) begin
			region  = dmem_decode_pkg::REG_CORE; // [R09]
		end else if (hitCommon) begin
			// every bank lands on the same bytes above the general ram
			region  = dmem_decode_pkg::REG_COMMON; // [R05]
			ramAddr = RAM_AW'(GRAM_DEPTH) + RAM_AW'(ofs[CW-1:0]);
		end else if (hitPeriph) begin
			region  = dmem_decode_pkg::REG_PERIPH; // [R01] [R02]
		end else if (hitGram) begin
			region  = dmem_decode_pkg::REG_GRAM; // [R03]
			ramAddr = RAM_AW'(gramIdx);
		end
	end

	// strobes follow the winning region; a hole gets no strobe, so a
	// write there is simply dropped [R06]
	always_comb begin
		coreSel   = 1'b0;
		periphSel = 1'b0;
		ramWe     = 1'b0;
		if (reqValid) begin
			case (region)
				dmem_decode_pkg::REG_CORE: begin
					coreSel = 1'b1; // [R09]
				end
				dmem_decode_pkg::REG_PERIPH: begin
					periphSel = 1'b1; // [R01] [R02]
				end
				dmem_decode_pkg::REG_GRAM,
				dmem_decode_pkg::REG_COMMON: begin
					ramWe = reqWrite; // [R03] [R05]
				end
				default: begin
					ramWe = 1'b0; // [R06]
				end
			endcase
		end
	end

	// register side sees the raw address and both local indices
	assign regAddr     = reqAddr;
	assign coreIndex   = ofs[3:0];
	assign periphIndex = ofs - OW'(dmem_decode_pkg::CORE_REGS);

	dmem_ram #(
		.DEPTH(RAM_DEPTH),
		.AW   (RAM_AW)
	) u_ram (
		.clk  (clk),
		.we   (ramWe),
		.addr (ramAddr),
		.wdata(reqWdata),
		.rdata(ramRdata)
	);

	// only reads get an answer; the region is kept so the mux below
	// knows where the byte comes from one cycle later
	always_comb begin
		nxt_rspValid  = reqValid && !reqWrite;
		nxt_rspRegion = region;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rspValid_ff  <= 1'b0;
			rspRegion_ff <= dmem_decode_pkg::REG_NONE;
		end else begin
			rspValid_ff  <= nxt_rspValid;
			rspRegion_ff <= nxt_rspRegion;
		end
	end

	// register data arrives from the far side in the answer cycle, so
	// it is muxed here rather than registered a second time, which
	// would cost a cycle of read latency; holes and idle give zero [R06]
	assign rspValid = rspValid_ff;
	always_comb begin
		rspData = 8'h00;
		if (rspValid_ff) begin
			case (rspRegion_ff)
				dmem_decode_pkg::REG_CORE: begin
					rspData = coreRdata; // [R09]
				end
				dmem_decode_pkg::REG_PERIPH: begin
					rspData = periphRdata; // [R01]
				end
				dmem_decode_pkg::REG_GRAM,
				dmem_decode_pkg::REG_COMMON: begin
					rspData = ramRdata; // [R03] [R05]
				end
				default: begin
					rspData = 8'h00; // [R06]
				end
			endcase
		end
	end
endmodule : banked_data_memory_decoder

//--- hw/dmem_decode_pkg.sv
// constants for the banked data memory decoder
package dmem_decode_pkg;
	localparam int ADDR_W          = 13;
	localparam int BANK_W          = 6;
	localparam int OFS_W           = 7;
	localparam int NUM_BANKS       = 64;
	localparam int BANK_BYTES      = 128;
	localparam int CORE_REGS       = 12;
	localparam int PERIPH_SHORT    = 20;
	localparam int PERIPH_LONG     = 100;
	localparam int LONG_FIRST_BANK = 60;
	localparam int GRAM_MAX        = 80;
	localparam int COMMON_BASE     = 112;
	localparam int COMMON_BYTES    = 16;
	localparam int GRAM_BANKS      = 13;
	localparam int LIN_BASE        = 8192;
	localparam logic [ADDR_W-1:0] LIN_BASE_ADDR = 13'h0000;
	typedef enum logic [2:0] {
		REG_CORE,
		REG_PERIPH,
		REG_GRAM,
		REG_COMMON,
		REG_NONE
	} region_t;
endpackage : dmem_decode_pkg

//--- hw/dmem_ram.sv
// single-port byte memory with registered read data
`timescale 1ns/1ps
module dmem_ram #(
	parameter int DEPTH = 1024,
	parameter int AW    = 10
) (
	input  wire logic         clk,    // system clock
	input  wire logic         we,     // write strobe
	input  wire logic [AW-1:0] addr,  // byte address
	input  wire logic [7:0]   wdata,  // write data
	output logic      [7:0]   rdata   // registered read data
);
	logic [7:0] mem [DEPTH];
	logic [7:0] nxt_rdata;

	always_comb begin
		nxt_rdata = mem[addr];
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= nxt_rdata;
	end
endmodule : dmem_ram

//--- sim/dmem_decode_chk.sv
// port assertions for the banked data memory decoder
`timescale 1ns/1ps
module dmem_decode_chk #(
	parameter int GRAM_BANKS = dmem_decode_pkg::GRAM_BANKS
) (
	input wire logic        clk,          // system clock
	input wire logic        rst,          // synchronous reset, high
	input wire logic        reqValid,     // request strobe
	input wire logic        reqWrite,     // write when high
	input wire logic        reqLinear,    // linear ram access
	input wire logic [12:0] reqAddr,      // request address
	input wire logic [12:0] regAddr,      // address to registers
	input wire logic [7:0]  reqWdata,     // write data
	input wire logic [7:0]  coreRdata,    // core read data
	input wire logic [7:0]  periphRdata,  // peripheral read data
	input wire logic [7:0]  rspData,      // response data
	input wire logic        coreSel,      // core strobe
	input wire logic        periphSel,    // peripheral strobe
	input wire logic        rspValid,     // response valid
	input wire logic [3:0]  coreIndex,    // core register index
	input wire logic [6:0]  periphIndex   // peripheral index
);
	logic [5:0] bank;
	logic [6:0] ofs;
	logic       bnk;
	assign bank = reqAddr[12:7];
	assign ofs  = reqAddr[6:0];
	assign bnk  = reqValid && !reqLinear;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence rdReq; reqValid && !reqWrite; endsequence
	sequence coreRd; rdReq ##0 (bnk && ofs < 12); endsequence
	sequence periphRd; rdReq ##0 periphSel; endsequence
	AST_CORE_SEL: assert property (bnk && ofs < 12 |-> coreSel &&
		!periphSel && coreIndex == ofs[3:0]) else $error("core select");
	AST_PERIPH_SHORT: assert property (bnk && bank < 60 &&
		ofs inside {[12:31]} |-> periphSel && periphIndex == ofs - 7'h0c)
		else $error("short peripheral region");
	AST_PERIPH_LONG: assert property (bnk && bank >= 60 &&
		ofs inside {[12:111]} |-> periphSel && periphIndex == ofs - 7'h0c)
		else $error("long region");
	AST_GRAM_QUIET: assert property (bnk && bank < 60 &&
		ofs >= 32 |-> !periphSel && !coreSel) else $error("ram select");
	AST_COMMON_QUIET: assert property (bnk && ofs >= 112 |->
		!coreSel && !periphSel) else $error("common select");
	AST_LINEAR_QUIET: assert property (reqValid && reqLinear |->
		!coreSel && !periphSel) else $error("linear select");
	AST_ADDR_PASS: assert property (coreSel || periphSel |->
		reqValid && regAddr == reqAddr) else $error("register address");
	AST_CORE_RSP: assert property (coreRd |=>
		rspValid && rspData == coreRdata) else $error("core read data");
	AST_PERIPH_RSP: assert property (periphRd |=>
		rspValid && rspData == periphRdata) else $error("peripheral read data");
	AST_NO_RSP: assert property (!(reqValid && !reqWrite) |=>
		!rspValid && rspData == 8'h00) else $error("idle response");
	AST_UNIMPL_ZERO: assert property (rdReq ##0 (bnk && bank < 60 &&
		bank >= GRAM_BANKS && ofs inside {[32:111]}) |=> rspValid &&
		rspData == 8'h00) else $error("unimplemented read");
endmodule : dmem_decode_chk
bind banked_data_memory_decoder dmem_decode_chk #(
	.GRAM_BANKS(GRAM_BANKS)) chk (.*);

//--- sim/core_side_model.sv
// far-side model answering core and peripheral register reads
`timescale 1ns/1ps
module core_side_model (
	input  wire logic        clk,         // system clock
	input  wire logic        coreSel,     // core access
	input  wire logic        periphSel,   // peripheral access
	input  wire logic [12:0] regAddr,     // register address
	output logic      [7:0]  coreRdata,   // core data
	output logic      [7:0]  periphRdata  // peripheral data
);
	// unselected cycles toggle so stale data cannot pass for a match
	always @(posedge clk) begin
		coreRdata <= coreSel ? regAddr[7:0] ^ 8'h5a : ~coreRdata;
		periphRdata <= periphSel ? regAddr[7:0] ^ 8'ha5 : ~periphRdata;
	end
endmodule : core_side_model

//--- sim/tb.sv
// self-checking bench for the banked data memory decoder
`timescale 1ns/1ps
module tb;
	localparam int GB = 2;
	logic clk = 0, rst = 1, reqValid = 0, reqWrite = 0, reqLinear = 0;
	logic [12:0] reqAddr = '0, regAddr;
	logic [7:0] reqWdata = '0, coreRdata, periphRdata, rspData, eD, expD;
	logic coreSel, periphSel, rspValid, eV = 0, expV = 0;
	logic [3:0] coreIndex;
	logic [6:0] periphIndex;
	logic [7:0] mem [0:175];
	int err_total = 0, compares = 0, cyc = 0, seed = 32'h02993eab, k;
	always #12.5 clk = ~clk;
	banked_data_memory_decoder #(.GRAM_BANKS(GB)) dut (.*);
	core_side_model cpu (.*);
	function automatic int loc(logic l, logic [12:0] a);
		if (l) return a < GB * 80 ? int'(a) : -1;
		if (a[6:0] < 12) return -2;
		if (a[6:0] >= 112) return GB * 80 - 112 + a[6:0];
		if (a[12:7] >= 60 || a[6:0] < 32) return -3;
		return a[12:7] < GB ? a[12:7] * 80 + a[6:0] - 32 : -1;
	endfunction : loc
	task automatic op(logic v, w, l, logic [12:0] a);
		int p;
		logic [7:0] d;
		if (l) a = a % 200;
		p = loc(l, a);
		d = 8'($random(seed));
		@(posedge clk);
		{reqValid, reqWrite, reqLinear, reqAddr, reqWdata} <= {v, w, l, a, d};
		eV <= v && !w;
		eD <= p >= 0 ? mem[p] : p == -2 ? a[7:0] ^ 8'h5a :
			p == -3 ? a[7:0] ^ 8'ha5 : 8'h00;
		if (v && w && p >= 0) mem[p] = d;
	endtask : op
	task automatic complete_run();
		if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	always @(posedge clk) {expV, expD} <= {eV, eD};
	always @(posedge clk) if (++cyc > 6000) begin
		err_total++;
		complete_run();
	end
	always @(negedge clk) if (!rst) begin
		compares++;
		if (rspValid !== expV || rspData !== (expV ? expD : 8'h00)) begin
			err_total++;
			$display("[FAIL] %0t read response mismatch", $time);
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		// fill every ram byte first: ram contents survive reset unset
		for (k = 0; k < 176; k++) op(1, 1, k < 160, 13'(k < 160 ? k : 'h1ed0 + k));
		// corner cases: one common byte seen from two banks, one general
		// byte seen linear and banked, and a hole above the last ram bank
		op(1, 1, 0, 13'h0070);
		op(1, 0, 0, 13'h1ff0);
		op(1, 1, 1, 13'h0050);
		op(1, 0, 0, 13'h00a0);
		op(1, 0, 0, 13'h0c20);
		for (k = 0; k < 4000; k++) op(1'($random(seed)), 1'($random(seed)),
			($random(seed) & 3) == 0, 13'($random(seed)));
		op(0, 0, 0, 13'h0000);
		op(0, 0, 0, 13'h0000);
		complete_run();
	end
endmodule : tb
